// ---- core/rcts_trim_status.sv ----
// Trim status, flags, lock report and control registers over APB
//
// Decided for this implementation: register access over APB.
`include "rcts_consts.svh"

module rcts_trim_status (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, high
  input rcts_pkg::rcts_apb_req_s apbReq, // APB request
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input rcts_pkg::rcts_eng_in_s eng0, // Engine 0 status lines
  input rcts_pkg::rcts_eng_in_s eng1, // Engine 1 status lines
  input wire logic refClockError, // Crystal reference drifted
  output logic [1:0] osc0TrimTargetSelect, // Engine 0 target
  output logic [1:0] osc1TrimTargetSelect, // Engine 1 target
  output logic trimIrq // Trim interrupt, level
);

  rcts_pkg::rcts_state_s s;
  rcts_pkg::rcts_state_s next_s;

  logic active0;
  logic active1;
  logic limitHit0;
  logic limitHit1;
  logic setupPhase;
  logic writeAccess;
  logic clkErrSet0;
  logic clkErrSet1;
  logic failSet0;
  logic failSet1;
  logic [31:0] w1c;

  // Decode of mapped addresses
  function automatic logic addrHit(input logic [11:0] addr);
    addrHit = (addr == `RCTS_OFF_CTL0) || (addr == `RCTS_OFF_IEN) ||
              (addr == `RCTS_OFF_STATUS) || (addr == `RCTS_OFF_CTL1);
  endfunction

  // Control register image for a read
  function automatic logic [31:0] ctlWord(input rcts_pkg::rcts_ctl_s c);
    ctlWord = `RCTS_RESET_WORD;
    ctlWord[`RCTS_CTL_SEL_LSB +: 2] = c.trimTargetSelect;
    ctlWord[`RCTS_CTL_RETRY_LSB +: 2] = c.updateRetryLimit;
    ctlWord[`RCTS_CTL_STOP] = c.stopOnClockError;
  endfunction

  // Control fields from a written word
  function automatic rcts_pkg::rcts_ctl_s ctlFields(input logic [31:0] d);
    ctlFields.trimTargetSelect = d[`RCTS_CTL_SEL_LSB +: 2];
    ctlFields.updateRetryLimit = d[`RCTS_CTL_RETRY_LSB +: 2];
    ctlFields.stopOnClockError = d[`RCTS_CTL_STOP];
  endfunction

  // Engine trims only with code 01; 10 and 11 leave it idle
  function automatic logic selActive(input logic [1:0] sel);
    selActive = (sel == `RCTS_SEL_ON);
  endfunction

  // Sticky flag; a hardware set wins over a write-one clear
  function automatic logic flagNext(
    input logic set,
    input logic held,
    input logic clear
  );
    flagNext = set | (held & ~clear);
  endfunction

  // Status register image; unlisted bits stay zero
  function automatic logic [31:0] statusWord(
    input rcts_pkg::rcts_state_s st
  );
    statusWord = `RCTS_RESET_WORD;
    statusWord[`RCTS_BIT_LOCK0] = st.osc0LockStatus;
    statusWord[`RCTS_BIT_FAIL0] = st.flags.osc0TrimFailFlag;
    statusWord[`RCTS_BIT_CLKERR0] = st.flags.osc0ClockErrorFlag;
    statusWord[`RCTS_BIT_LOCK1] = st.osc1LockStatus;
    statusWord[`RCTS_BIT_FAIL1] = st.flags.osc1TrimFailFlag;
    statusWord[`RCTS_BIT_CLKERR1] = st.flags.osc1ClockErrorFlag;
  endfunction

  // Enable register image
  function automatic logic [31:0] ienWord(input rcts_pkg::rcts_ien_s e);
    ienWord = `RCTS_RESET_WORD;
    ienWord[`RCTS_BIT_FAIL0] = e.osc0TrimFailIrqEnable;
    ienWord[`RCTS_BIT_CLKERR0] = e.osc0ClockErrorIrqEnable;
    ienWord[`RCTS_BIT_FAIL1] = e.osc1TrimFailIrqEnable;
    ienWord[`RCTS_BIT_CLKERR1] = e.osc1ClockErrorIrqEnable;
  endfunction

  // Read data multiplexer
  function automatic logic [31:0] readMux(
    input logic [11:0] addr,
    input rcts_pkg::rcts_state_s st
  );
    unique case (addr)
      `RCTS_OFF_CTL0: readMux = ctlWord(st.ctl0);
      `RCTS_OFF_IEN: readMux = ienWord(st.ien);
      `RCTS_OFF_STATUS: readMux = statusWord(st);
      `RCTS_OFF_CTL1: readMux = ctlWord(st.ctl1);
      default: readMux = `RCTS_RESET_WORD;
    endcase
  endfunction

  // Engine activity follows the target selection
  assign active0 = selActive(s.ctl0.trimTargetSelect);
  assign active1 = selActive(s.ctl1.trimTargetSelect);

  // Retry counter of engine 0
  rcts_retry_counter retry0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .active(active0),
    .locked(eng0.locked),
    .trimUpdate(eng0.trimUpdate),
    .updateRetryLimit(s.ctl0.updateRetryLimit),
    .limitHit(limitHit0)
  );

  // Retry counter of engine 1
  rcts_retry_counter retry1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .active(active1),
    .locked(eng1.locked),
    .trimUpdate(eng1.trimUpdate),
    .updateRetryLimit(s.ctl1.updateRetryLimit),
    .limitHit(limitHit1)
  );

  // APB phase decode; a write lands on the last access edge
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign writeAccess = apbReq.psel & apbReq.penable & s.pready &
                       apbReq.pwrite & addrHit(apbReq.paddr);

  // Clear mask for the status register
  assign w1c = (writeAccess && apbReq.paddr == `RCTS_OFF_STATUS) ?
               apbReq.pwdata : `RCTS_RESET_WORD;

  // Hardware events, only while an engine trims
  assign clkErrSet0 = active0 & (eng0.clockError | refClockError);
  assign clkErrSet1 = active1 & eng1.clockError;
  assign failSet0 = limitHit0 & ~eng0.locked;
  assign failSet1 = limitHit1 & ~eng1.locked;

  // Next state of the whole block
  always_comb begin
    next_s = s;

    // Bus answer: ready in the first access cycle
    next_s.pready = setupPhase;
    next_s.pslverr = 1'b0;
    if (setupPhase) begin
      next_s.prdata = readMux(apbReq.paddr, s);
      next_s.pslverr = ~addrHit(apbReq.paddr);
    end

    // Lock status follows the engines, writes ignored
    next_s.osc0LockStatus = eng0.locked;
    next_s.osc1LockStatus = eng1.locked;

    // Software writes to control and enable registers
    if (writeAccess) begin
      unique case (apbReq.paddr)
        `RCTS_OFF_CTL0: next_s.ctl0 = ctlFields(apbReq.pwdata);
        `RCTS_OFF_CTL1: next_s.ctl1 = ctlFields(apbReq.pwdata);
        `RCTS_OFF_IEN: begin
          next_s.ien.osc0TrimFailIrqEnable =
            apbReq.pwdata[`RCTS_BIT_FAIL0];
          next_s.ien.osc0ClockErrorIrqEnable =
            apbReq.pwdata[`RCTS_BIT_CLKERR0];
          next_s.ien.osc1TrimFailIrqEnable =
            apbReq.pwdata[`RCTS_BIT_FAIL1];
          next_s.ien.osc1ClockErrorIrqEnable =
            apbReq.pwdata[`RCTS_BIT_CLKERR1];
        end
        default: begin
          // Status holds only clear-on-one and read-only bits
        end
      endcase
    end

    // Write one to clear; a set in the same cycle wins
    next_s.flags.osc0TrimFailFlag = flagNext(failSet0,
      s.flags.osc0TrimFailFlag, w1c[`RCTS_BIT_FAIL0]);
    next_s.flags.osc0ClockErrorFlag = flagNext(clkErrSet0,
      s.flags.osc0ClockErrorFlag, w1c[`RCTS_BIT_CLKERR0]);
    next_s.flags.osc1TrimFailFlag = flagNext(failSet1,
      s.flags.osc1TrimFailFlag, w1c[`RCTS_BIT_FAIL1]);
    next_s.flags.osc1ClockErrorFlag = flagNext(clkErrSet1,
      s.flags.osc1ClockErrorFlag, w1c[`RCTS_BIT_CLKERR1]);

    // Engine 0 halt: failure always, clock error only if stop set
    if (failSet0) begin
      next_s.ctl0.trimTargetSelect = `RCTS_SEL_OFF;
    end else if (clkErrSet0 && s.ctl0.stopOnClockError) begin
      next_s.ctl0.trimTargetSelect = `RCTS_SEL_OFF;
    end

    // Engine 1 halt: failure always, clock error only if stop set
    if (failSet1) begin
      next_s.ctl1.trimTargetSelect = `RCTS_SEL_OFF;
    end else if (clkErrSet1 && s.ctl1.stopOnClockError) begin
      next_s.ctl1.trimTargetSelect = `RCTS_SEL_OFF;
    end

    // Interrupt from flags and enables; lock bits take no part
    next_s.trimIrq =
      (next_s.flags.osc1ClockErrorFlag &
       next_s.ien.osc1ClockErrorIrqEnable) |
      (next_s.flags.osc1TrimFailFlag &
       next_s.ien.osc1TrimFailIrqEnable) |
      (next_s.flags.osc0ClockErrorFlag &
       next_s.ien.osc0ClockErrorIrqEnable) |
      (next_s.flags.osc0TrimFailFlag &
       next_s.ien.osc0TrimFailIrqEnable);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign osc0TrimTargetSelect = s.ctl0.trimTargetSelect;
  assign osc1TrimTargetSelect = s.ctl1.trimTargetSelect;
  assign trimIrq = s.trimIrq;

endmodule // rcts_trim_status

// ---- core/rcts_consts.svh ----
// Offsets, field positions, reset values and limits of the trim status block
`ifndef RCTS_CONSTS_SVH
`define RCTS_CONSTS_SVH

// Register byte offsets
`define RCTS_OFF_CTL0 12'h080
`define RCTS_OFF_IEN 12'h084
`define RCTS_OFF_STATUS 12'h088
`define RCTS_OFF_CTL1 12'h090

// Status and interrupt enable bit positions
`define RCTS_BIT_LOCK0 0
`define RCTS_BIT_FAIL0 1
`define RCTS_BIT_CLKERR0 2
`define RCTS_BIT_LOCK1 8
`define RCTS_BIT_FAIL1 9
`define RCTS_BIT_CLKERR1 10

// Control register field positions
`define RCTS_CTL_SEL_LSB 0
`define RCTS_CTL_RETRY_LSB 6
`define RCTS_CTL_STOP 8

// Target selection codes
`define RCTS_SEL_OFF 2'h0
`define RCTS_SEL_ON 2'h1

// Retry limit codes
`define RCTS_RETRY_64 2'h0
`define RCTS_RETRY_128 2'h1

// Last count before the limit is reached (limit minus one)
`define RCTS_LAST_64 10'h03F
`define RCTS_LAST_128 10'h07F
`define RCTS_LAST_512 10'h1FF

// Reset and fill values
`define RCTS_RESET_WORD 32'h00000000
`define RCTS_RESET_CNT 10'h000
`define RCTS_CNT_STEP 10'h001

`endif

// ---- core/rcts_pkg.sv ----
// Types shared by the trim status block and its retry counter
package rcts_pkg;

  // APB request from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcts_apb_req_s;

  // Status lines from one trim engine
  typedef struct packed {
    logic locked;
    logic clockError;
    logic trimUpdate;
  } rcts_eng_in_s;

  // Per-engine control fields
  typedef struct packed {
    logic stopOnClockError;
    logic [1:0] updateRetryLimit;
    logic [1:0] trimTargetSelect;
  } rcts_ctl_s;

  // Interrupt enables
  typedef struct packed {
    logic osc1ClockErrorIrqEnable;
    logic osc1TrimFailIrqEnable;
    logic osc0ClockErrorIrqEnable;
    logic osc0TrimFailIrqEnable;
  } rcts_ien_s;

  // Sticky flags
  typedef struct packed {
    logic osc1ClockErrorFlag;
    logic osc1TrimFailFlag;
    logic osc0ClockErrorFlag;
    logic osc0TrimFailFlag;
  } rcts_flags_s;

  // Whole state of the status block
  typedef struct packed {
    rcts_ctl_s ctl0;
    rcts_ctl_s ctl1;
    rcts_ien_s ien;
    rcts_flags_s flags;
    logic osc0LockStatus;
    logic osc1LockStatus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic trimIrq;
  } rcts_state_s;

  // State of one retry counter
  typedef struct packed {
    logic [9:0] count;
    logic limitHit;
  } rcts_cnt_s;

endpackage

// ---- core/rcts_retry_counter.sv ----
// Trim update counter that flags the retry limit for one engine
`include "rcts_consts.svh"

module rcts_retry_counter (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, high
  input wire logic active, // Engine trimming enabled
  input wire logic locked, // Engine frequency locked
  input wire logic trimUpdate, // One trim value update done
  input wire logic [1:0] updateRetryLimit, // Limit code
  output logic limitHit // Pulse: limit reached unlocked
);

  rcts_pkg::rcts_cnt_s s;
  rcts_pkg::rcts_cnt_s next_s;

  // Last count value for a limit code
  function automatic logic [9:0] lastCount(input logic [1:0] code);
    unique case (code)
      `RCTS_RETRY_64: lastCount = `RCTS_LAST_64;
      `RCTS_RETRY_128: lastCount = `RCTS_LAST_128;
      default: lastCount = `RCTS_LAST_512;
    endcase
  endfunction

  // Count updates, restart on lock, idle or limit
  always_comb begin
    next_s = s;
    next_s.limitHit = 1'b0;
    if (!active || locked) begin
      next_s.count = `RCTS_RESET_CNT;
    end else if (trimUpdate) begin
      if (s.count == lastCount(updateRetryLimit)) begin
        next_s.limitHit = 1'b1;
        next_s.count = `RCTS_RESET_CNT;
      end else begin
        next_s.count = 10'(s.count + `RCTS_CNT_STEP);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign limitHit = s.limitHit;

endmodule // rcts_retry_counter

// ---- verification/rcts_trim_status_properties.sv ----
// Port assertions of the trim status block and their bind
`include "rcts_consts.svh"
module rcts_trim_status_chk (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input rcts_pkg::rcts_apb_req_s apbReq, // Bus request
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input rcts_pkg::rcts_eng_in_s eng0, // Engine 0 lines
  input rcts_pkg::rcts_eng_in_s eng1, // Engine 1 lines
  input wire logic refClockError, // Reference drift
  input wire logic [1:0] osc0TrimTargetSelect, // Engine 0 target
  input wire logic [1:0] osc1TrimTargetSelect, // Engine 1 target
  input wire logic trimIrq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic mapped;
  logic err0;
  logic stop0;
  logic stop1;
  logic ienAny;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Write strobe, decode and engine 0 error source
  assign wr = apbReq.psel & apbReq.penable & pready & apbReq.pwrite;
  assign mapped = apbReq.paddr inside {`RCTS_OFF_CTL0, `RCTS_OFF_IEN,
    `RCTS_OFF_STATUS, `RCTS_OFF_CTL1};
  assign err0 = eng0.clockError | refClockError;
  // Shadow of stop controls and interrupt enables
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stop0 <= 1'b0;
      stop1 <= 1'b0;
      ienAny <= 1'b0;
    end else if (wr) begin
      if (apbReq.paddr == `RCTS_OFF_CTL0) stop0 <= apbReq.pwdata[8];
      if (apbReq.paddr == `RCTS_OFF_CTL1) stop1 <= apbReq.pwdata[8];
      if (apbReq.paddr == `RCTS_OFF_IEN) ienAny <= |apbReq.pwdata[10:0];
    end
  end
  property p_ready;
    apbReq.psel && !apbReq.penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing wrong");
  property p_unmapped;
    apbReq.psel && !apbReq.penable && !mapped |=> pslverr && prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
  property p_mapped;
    apbReq.psel && !apbReq.penable && mapped |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped error");
  property p_reserved;
    pready && !apbReq.pwrite && apbReq.paddr == `RCTS_OFF_STATUS
      |-> (prdata & 32'hFFFFF8F8) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits");
  property p_stop0;
    err0 && osc0TrimTargetSelect == 2'h1 && stop0
      |=> osc0TrimTargetSelect == 2'h0;
  endproperty
  a_stop0: assert property (p_stop0) else $error("target 0 kept");
  property p_stop1;
    eng1.clockError && osc1TrimTargetSelect == 2'h1 && stop1
      |=> osc1TrimTargetSelect == 2'h0;
  endproperty
  a_stop1: assert property (p_stop1) else $error("target 1 kept");
  property p_no_stop0;
    err0 && osc0TrimTargetSelect == 2'h1 && !stop0 && !wr
      && !$past(eng0.trimUpdate) |=> $stable(osc0TrimTargetSelect);
  endproperty
  a_no_stop0: assert property (p_no_stop0) else $error("trim halted");
  property p_irq;
    trimIrq |-> ienAny;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
  property p_reset;
    disable iff (1'b0) reset |=> !pready && !trimIrq
      && osc0TrimTargetSelect == 2'h0 && osc1TrimTargetSelect == 2'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs after reset");
endmodule // rcts_trim_status_chk

bind rcts_trim_status rcts_trim_status_chk u_chk (.clk_sys(clk_sys),
  .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .eng0(eng0), .eng1(eng1),
  .refClockError(refClockError),
  .osc0TrimTargetSelect(osc0TrimTargetSelect),
  .osc1TrimTargetSelect(osc1TrimTargetSelect), .trimIrq(trimIrq));

// ---- verification/rcts_trim_status_test.sv ----
// Self-checking testbench of the trim status block
`include "rcts_consts.svh"
`define CHK(a, b) check(32'(a), 32'(b))
module rcts_trim_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
  } rcts_row_s;
  localparam logic [11:0] ST = `RCTS_OFF_STATUS;
  logic clk_sys;
  logic reset;
  logic refClockError;
  logic pready;
  logic pslverr;
  logic trimIrq;
  logic rdErr;
  logic [31:0] prdata;
  logic [31:0] rdData;
  logic [1:0] osc0TrimTargetSelect;
  logic [1:0] osc1TrimTargetSelect;
  rcts_pkg::rcts_apb_req_s apbReq;
  rcts_pkg::rcts_eng_in_s eng0;
  rcts_pkg::rcts_eng_in_s eng1;
  int errTotal = 0;
  int nChecks = 0;
  rcts_row_s rows [5] = '{
    '{`RCTS_OFF_CTL0, 32'hFFFFFFFF, 32'h000001C3, 1'b0},
    '{`RCTS_OFF_IEN, 32'hFFFFFFFF, 32'h00000606, 1'b0},
    '{`RCTS_OFF_CTL1, 32'hFFFFFFFF, 32'h000001C3, 1'b0},
    '{ST, 32'hFFFFFFFF, 32'h00000000, 1'b0},
    '{12'h08C, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  rcts_trim_status u_dut (.clk_sys(clk_sys), .reset(reset), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng0(eng0),
    .eng1(eng1), .refClockError(refClockError),
    .osc0TrimTargetSelect(osc0TrimTargetSelect),
    .osc1TrimTargetSelect(osc1TrimTargetSelect), .trimIrq(trimIrq));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n >= 20) begin
      errTotal++;
      completeRun();
    end
  endtask

  task automatic updates(input logic e1, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      eng0.trimUpdate <= !e1;
      eng1.trimUpdate <= e1;
      @(posedge clk_sys);
      eng0.trimUpdate <= 1'b0;
      eng1.trimUpdate <= 1'b0;
    end
  endtask

  // Clock error from source 0 engine 0, 1 reference, 2 engine 1
  task automatic errRun(input int src, input logic stop);
    logic [11:0] ctl;
    logic [31:0] b;
    ctl = (src == 2) ? `RCTS_OFF_CTL1 : `RCTS_OFF_CTL0;
    b = (src == 2) ? 32'h00000400 : 32'h00000004;
    apb(1'b1, ctl, {23'h0, stop, 8'h01});
    @(posedge clk_sys);
    eng0.clockError <= (src == 0);
    refClockError <= (src == 1);
    eng1.clockError <= (src == 2);
    @(posedge clk_sys);
    {eng0.clockError, refClockError, eng1.clockError} <= 3'b000;
    cyc(2);
    `CHK(src == 2 ? osc1TrimTargetSelect : osc0TrimTargetSelect, !stop);
    `CHK(trimIrq, 1'b1);
    apb(1'b0, ST, 32'h0);
    `CHK(rdData, b);
    apb(1'b1, `RCTS_OFF_IEN, 32'h0);
    cyc(1);
    `CHK(trimIrq, 1'b0);
    apb(1'b1, `RCTS_OFF_IEN, 32'h606);
    apb(1'b1, ST, b);
    cyc(1);
    `CHK(trimIrq, 1'b0);
    apb(1'b1, ctl, 32'h0);
    $display("clock error test %0d done", src);
  endtask

  // Retry limit reached with no lock
  task automatic failRun(input logic e1, input logic [1:0] c, input int n);
    logic [11:0] ctl;
    logic [31:0] b;
    ctl = e1 ? `RCTS_OFF_CTL1 : `RCTS_OFF_CTL0;
    b = e1 ? 32'h00000200 : 32'h00000002;
    apb(1'b1, ctl, {24'h0, c, 6'h01});
    updates(e1, n - 1);
    cyc(3);
    `CHK(trimIrq, 1'b0);
    updates(e1, 1);
    cyc(3);
    `CHK(e1 ? osc1TrimTargetSelect : osc0TrimTargetSelect, 2'h0);
    `CHK(trimIrq, 1'b1);
    apb(1'b1, ST, 32'h0);
    apb(1'b0, ST, 32'h0);
    `CHK(rdData, b);
    apb(1'b1, ST, b);
    apb(1'b0, ST, 32'h0);
    `CHK(rdData, 32'h0);
    $display("fail test limit %0d done", n);
  endtask

  // Watchdog
  initial begin
    cyc(100000);
    errTotal++;
    completeRun();
  end

  // Main sequence
  initial begin
    reset <= 1'b1;
    apbReq <= '0;
    eng0 <= '0;
    eng1 <= '0;
    refClockError <= 1'b0;
    cyc(8);
    reset <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0);
      `CHK(rdData, 32'h0);
      apb(1'b1, rows[i].addr, rows[i].wdata);
      `CHK(rdErr, rows[i].err);
      apb(1'b0, rows[i].addr, 32'h0);
      `CHK(rdData, rows[i].rdata);
    end
    $display("register table test done");
    apb(1'b1, `RCTS_OFF_CTL0, 32'h0);
    apb(1'b1, `RCTS_OFF_CTL1, 32'h0);
    errRun(0, 1'b1);
    errRun(1, 1'b0);
    errRun(2, 1'b1);
    failRun(1'b0, 2'h0, 64);
    failRun(1'b1, 2'h1, 128);
    failRun(1'b0, 2'h2, 512);
    // Reserved target code keeps engine 0 idle
    apb(1'b1, `RCTS_OFF_CTL0, 32'h103);
    @(posedge clk_sys);
    eng0.clockError <= 1'b1;
    refClockError <= 1'b1;
    @(posedge clk_sys);
    eng0.clockError <= 1'b0;
    refClockError <= 1'b0;
    updates(1'b0, 64);
    cyc(3);
    `CHK(osc0TrimTargetSelect, 2'h3);
    `CHK(trimIrq, 1'b0);
    apb(1'b0, ST, 32'h0);
    `CHK(rdData, 32'h0);
    $display("reserved target test done");
    apb(1'b1, `RCTS_OFF_CTL0, 32'h1);
    updates(1'b0, 40);
    eng0.locked <= 1'b1;
    eng1.locked <= 1'b1;
    cyc(3);
    apb(1'b1, ST, 32'h101);
    apb(1'b0, ST, 32'h0);
    `CHK(rdData, 32'h101);
    `CHK(trimIrq, 1'b0);
    eng0.locked <= 1'b0;
    updates(1'b0, 40);
    cyc(3);
    `CHK(osc0TrimTargetSelect, 2'h1);
    $display("lock test done");
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    apb(1'b0, `RCTS_OFF_CTL0, 32'h0);
    `CHK(rdData, 32'h0);
    `CHK(osc0TrimTargetSelect, 2'h0);
    $display("second reset test done");
    completeRun();
  end
endmodule // rcts_trim_status_test
